/* File: hdl/fault_capture_readback.sv */
// Purpose: six-channel fault capture, flags and 16-bit serial readback
// Assumes: serial clock idles low, data sampled on its rising edge
// Notes: all pins except the flag enables pass two flops; serial clock must be well below clock_i/4
//
// How it works
// - detected fault latched, fault flag asserted
// - held latch ignores new faults until valid frame
// - select fall loads codes, releases fault flag
// - select rise re-arms latches only if valid
// - persisting fault recaptured after re-arm
// - first enable high-low-high clears all latches
// - invalid frame updates no register
// - frame is 16 bits, two bits per channel
// - latch updates only at a timer end, at re-arm with timers idle, or on clear
// - input on drives gate, starts timers
// - confirmed short: latch, gate low, retry timer
// - retry expiry re-drives gate, re-checks at filter and blanking end
// - after turn-off, below ground threshold latches fault
// - filter starts only toward a fault state
// - unread latch unchanged, takes live at valid end
// - no live fault: latch cleared, flag stays released
// - status flag low while drain below open threshold
// - each fault type has unique two-bit code
// - fault flag released when first enable or select low
// - input change starts channel blanking timer
`timescale 1ns/1ps
`default_nettype none
module fault_capture_readback
  import fault_capture_pkg::*;
#(
  parameter int CHANNELS = fault_capture_pkg::CH_COUNT,
  parameter int RETRY_COUNT = fault_capture_pkg::RETRY_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic master_enable_one_i,
  input wire logic master_enable_two_i,
  input wire logic [CHANNELS-1:0] cmd_in_i,
  input wire logic [CHANNELS-1:0] drain_above_short_ref_i,
  input wire logic [CHANNELS-1:0] drain_below_open_i,
  input wire logic [CHANNELS-1:0] drain_below_ground_i,
  input wire logic [CHANNELS-1:0] flag_enable_i,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_n_o,
  output logic status_flag_n_o,
  output logic status_flag_n_oe_n_o,
  output logic [CHANNELS-1:0] gate_drive_o,
  output logic [fault_capture_pkg::FRAME_BITS-1:0] config_word_o,
  output logic frame_valid_o
);
  import fault_capture_pkg::*;

  localparam int RETRY_W = $clog2(RETRY_COUNT + 1);
  localparam int PAD_BITS = FRAME_BITS - CODE_W * CHANNELS;

  // synchronised pins
  logic master_enable_one_s, master_enable_two_s, cs_n_s, sclk_s, mosi_s;
  logic [CHANNELS-1:0] cmd_s, above_short_s, below_open_s, below_ground_s;

  // edge history, all taken from second synchroniser stage
  logic cs_n_prev_reg, sclk_prev_reg, diag_prev_reg;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic diag_enable, enable_rise, clear_latches;

  // serial path
  logic [FRAME_BITS-1:0] tx_reg, rx_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic frame_ok, rearm_reg;

  // per-channel results
  logic [CODE_W*CHANNELS-1:0] latch_codes;
  logic [CHANNELS-1:0] latched, retry_wait, gate_w;

  // shared retry timer
  logic [RETRY_W-1:0] retry_cnt_reg;
  logic retry_go_reg;

  // any asserted channel gated by its flag enable
  function automatic logic any_masked(input logic [CHANNELS-1:0] v, input logic [CHANNELS-1:0] m);
    any_masked = |(v & m);
  endfunction

  sync2 #(
    .WIDTH(3),
    .INIT(3'h4)
  ) u_sync_ctrl (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .d_i({chip_select_n_i, sclk_i, mosi_i}),
    .q_o({cs_n_s, sclk_s, mosi_s})
  );

  sync2 #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_sync_ena (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .d_i({master_enable_one_i, master_enable_two_i}),
    .q_o({master_enable_one_s, master_enable_two_s})
  );

  sync2 #(
    .WIDTH(4 * CHANNELS),
    .INIT('0)
  ) u_sync_chan (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .d_i({cmd_in_i, drain_above_short_ref_i, drain_below_open_i, drain_below_ground_i}),
    .q_o({cmd_s, above_short_s, below_open_s, below_ground_s})
  );

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_n_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
      diag_prev_reg <= 1'b0;
    end else begin
      cs_n_prev_reg <= cs_n_s;
      sclk_prev_reg <= sclk_s;
      diag_prev_reg <= diag_enable;
    end
  end

  assign cs_fall = cs_n_prev_reg && !cs_n_s;
  assign cs_rise = !cs_n_prev_reg && cs_n_s;
  assign sclk_rise = !cs_n_s && !sclk_prev_reg && sclk_s;
  assign sclk_fall = !cs_n_s && sclk_prev_reg && !sclk_s;
  assign diag_enable = master_enable_one_s && master_enable_two_s;
  // either enable rising with the other high retriggers all blanking
  assign enable_rise = diag_enable && !diag_prev_reg;
  // latches stay cleared while the first enable is low
  assign clear_latches = !master_enable_one_s;

  // bit counter saturates so over-long frames stay invalid
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise && bit_cnt_reg != BIT_CNT_MAX) begin
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
    end
  end

  assign frame_ok = (bit_cnt_reg == BIT_CNT_FRAME);

  // receive side samples on rising serial clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_reg <= '0;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_s};
    end
  end

  // transmit side: snapshot at select fall, shift on falling clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_reg <= '0;
      miso_o <= 1'b0;
    end else if (cs_fall) begin
      tx_reg <= {{PAD_BITS{1'b0}}, latch_codes};
      miso_o <= (PAD_BITS > 0) ? 1'b0 : latch_codes[CODE_W*CHANNELS-1];
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
      miso_o <= tx_reg[FRAME_BITS-2];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_oe_n_o <= 1'b1;
    end else begin
      miso_oe_n_o <= cs_n_s;
    end
  end

  // received word only lands after a valid frame
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_word_o <= CONFIG_RESET;
      frame_valid_o <= 1'b0;
      rearm_reg <= 1'b0;
    end else begin
      frame_valid_o <= cs_rise && frame_ok;
      rearm_reg <= cs_rise && frame_ok;
      if (cs_rise && frame_ok) begin
        config_word_o <= rx_reg;
      end
    end
  end

  // one shared retry timer; first waiting channel starts a full period
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      retry_cnt_reg <= '0;
      retry_go_reg <= 1'b0;
    end else begin
      retry_go_reg <= 1'b0;
      if (retry_cnt_reg == '0) begin
        if (|retry_wait) begin
          retry_cnt_reg <= RETRY_W'(RETRY_COUNT);
        end
      end else if (retry_cnt_reg == RETRY_W'(1)) begin
        retry_cnt_reg <= '0;
        retry_go_reg <= 1'b1;
      end else begin
        retry_cnt_reg <= retry_cnt_reg - RETRY_W'(1);
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      fault_channel u_channel (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .diag_enable_i(diag_enable),
        .enable_rise_i(enable_rise),
        .clear_i(clear_latches),
        .cmd_i(cmd_s[ch]),
        .above_short_ref_i(above_short_s[ch]),
        .below_open_i(below_open_s[ch]),
        .below_ground_i(below_ground_s[ch]),
        .rearm_i(rearm_reg),
        .retry_go_i(retry_go_reg),
        .gate_o(gate_w[ch]),
        .latch_code_o(latch_codes[CODE_W*ch +: CODE_W]),
        .latched_o(latched[ch]),
        .retry_wait_o(retry_wait[ch])
      );
    end
  endgenerate

  assign gate_drive_o = gate_w;

  // fault flag: held latch, only while first enable and select are high
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe_n_o <= 1'b1;
    end else if (master_enable_one_s && cs_n_s && any_masked(latched, flag_enable_i)) begin
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe_n_o <= 1'b0;
    end else begin
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe_n_o <= 1'b1;
    end
  end

  // status flag follows the open-load comparison directly
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_flag_n_o <= 1'b1;
      status_flag_n_oe_n_o <= 1'b1;
    end else if (master_enable_one_s && any_masked(below_open_s, flag_enable_i)) begin
      status_flag_n_o <= 1'b0;
      status_flag_n_oe_n_o <= 1'b0;
    end else begin
      status_flag_n_o <= 1'b1;
      status_flag_n_oe_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/fault_capture_pkg.sv */
// Purpose: shared constants for the fault capture and readback block
// Assumes: 10 MHz system clock, six channels, 16-bit serial frames
// Notes: timing figures are plain defaults, not characterised values
package fault_capture_pkg;
  localparam int CH_COUNT = 6;
  localparam int FRAME_BITS = 16;
  localparam int CODE_W = 2;
  localparam int CLK_PERIOD_NS = 100;
  // channel fault codes
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OPEN = 2'h1;
  localparam logic [1:0] CODE_GROUND = 2'h2;
  localparam logic [1:0] CODE_SHORT = 2'h3;
  // least times round up to whole cycles
  localparam int BLANK_TIME_NS = 20000;
  localparam int FILTER_TIME_NS = 10000;
  localparam int RETRY_TIME_NS = 10000000;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYCLES = (RETRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;
  localparam int BIT_CNT_W = 5;
  localparam logic [4:0] BIT_CNT_MAX = 5'h11;
  localparam logic [4:0] BIT_CNT_FRAME = 5'h10;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  typedef enum logic [1:0] {DRIVE_OFF, DRIVE_ON, DRIVE_WAIT} drive_state_type;
endpackage

/* File: hdl/sync2.sv */
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs change slowly compared with the clock
// Notes: only the second stage is visible to logic
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/fault_channel.sv */
// Purpose: one channel: gate drive, blanking and filter timers, fault latch
// Assumes: comparator inputs already synchronised
// Notes: auto-retry timing comes from the shared timer in the top
`timescale 1ns/1ps
`default_nettype none
module fault_channel
  import fault_capture_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic diag_enable_i,
  input wire logic enable_rise_i,
  input wire logic clear_i,
  input wire logic cmd_i,
  input wire logic above_short_ref_i,
  input wire logic below_open_i,
  input wire logic below_ground_i,
  input wire logic rearm_i,
  input wire logic retry_go_i,
  output logic gate_o,
  output logic [1:0] latch_code_o,
  output logic latched_o,
  output logic retry_wait_o
);
  drive_state_type state_reg, state_next;
  logic [1:0] live_code, live_prev_reg;
  logic cmd_prev_reg;
  logic [TIMER_W-1:0] blank_reg, filter_reg;
  logic start_blank, start_filter, check, busy;

  // live comparison picks references by drive state
  always_comb begin
    live_code = CODE_NONE;
    if (diag_enable_i) begin
      if (state_reg == DRIVE_ON) begin
        live_code = above_short_ref_i ? CODE_SHORT : CODE_NONE;
      end else if (below_ground_i) begin
        live_code = CODE_GROUND;
      end else if (below_open_i) begin
        live_code = CODE_OPEN;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DRIVE_OFF: begin
        if (diag_enable_i && cmd_i) begin
          state_next = DRIVE_ON;
        end
      end
      DRIVE_ON: begin
        if (!diag_enable_i || !cmd_i) begin
          state_next = DRIVE_OFF;
        end else if (check && live_code == CODE_SHORT) begin
          state_next = DRIVE_WAIT;
        end
      end
      DRIVE_WAIT: begin
        if (!diag_enable_i || !cmd_i) begin
          state_next = DRIVE_OFF;
        end else if (retry_go_i) begin
          state_next = DRIVE_ON;
        end
      end
      default: state_next = DRIVE_OFF;
    endcase
  end

  assign start_blank = (cmd_i != cmd_prev_reg) || enable_rise_i ||
    (state_reg == DRIVE_WAIT && state_next == DRIVE_ON);
  // only a move toward a fault starts the filter
  assign start_filter = (live_code != live_prev_reg) && (live_code != CODE_NONE);
  assign busy = (blank_reg != '0) || (filter_reg != '0);
  assign check = (blank_reg == TIMER_W'(1)) || (filter_reg == TIMER_W'(1));
  assign retry_wait_o = (state_reg == DRIVE_WAIT);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= DRIVE_OFF;
      gate_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      gate_o <= (state_next == DRIVE_ON);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_prev_reg <= 1'b0;
      live_prev_reg <= CODE_NONE;
    end else begin
      cmd_prev_reg <= cmd_i;
      live_prev_reg <= live_code;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blank_reg <= '0;
      filter_reg <= '0;
    end else begin
      if (start_blank) begin
        blank_reg <= TIMER_W'(BLANK_CYCLES);
      end else if (blank_reg != '0) begin
        blank_reg <= blank_reg - TIMER_W'(1);
      end
      if (start_filter) begin
        filter_reg <= TIMER_W'(FILTER_CYCLES);
      end else if (filter_reg != '0) begin
        filter_reg <= filter_reg - TIMER_W'(1);
      end
    end
  end

  // latch only samples at timer ends or at re-arm with timers idle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_code_o <= CODE_NONE;
      latched_o <= 1'b0;
    end else if (clear_i) begin
      latch_code_o <= CODE_NONE;
      latched_o <= 1'b0;
    end else if (check && !latched_o && live_code != CODE_NONE) begin
      latch_code_o <= live_code;
      latched_o <= 1'b1;
    end else if (rearm_i && !busy) begin
      latch_code_o <= live_code;
      latched_o <= (live_code != CODE_NONE);
    end
  end
endmodule
`default_nettype wire

/* File: tb/fault_capture_readback_assertions.sv */
// Purpose: port-level checks on flags, select, gates and frame pulse
// Assumes: pins move on clock_i edges; three cycles of sync latency
// Notes: windows carry one spare cycle for sync phase
`timescale 1ns/1ps
`default_nettype none
module fault_capture_readback_assertions
  import fault_capture_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int RETRY_COUNT = 500
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic master_enable_one_i,
  input wire logic master_enable_two_i,
  input wire logic [CHANNELS-1:0] cmd_in_i,
  input wire logic [CHANNELS-1:0] drain_below_open_i,
  input wire logic [CHANNELS-1:0] flag_enable_i,
  input wire logic chip_select_n_i,
  input wire logic miso_oe_n_o,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe_n_o,
  input wire logic status_flag_n_o,
  input wire logic [CHANNELS-1:0] gate_drive_o,
  input wire logic [fault_capture_pkg::FRAME_BITS-1:0] config_word_o,
  input wire logic frame_valid_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_sel_low; !chip_select_n_i [*5]; endsequence
  sequence s_sel_high; chip_select_n_i [*5]; endsequence
  sequence s_open_on; (master_enable_one_i && (drain_below_open_i & flag_enable_i) != '0) [*4]; endsequence
  sequence s_open_off; (master_enable_one_i && (drain_below_open_i & flag_enable_i) == '0) [*4]; endsequence
  property p_flag_sel; s_sel_low |-> fault_flag_n_o && !miso_oe_n_o; endproperty
  a_flag_sel: assert property (p_flag_sel) else $error("fault flag or miso enable wrong in frame");
  property p_miso_idle; s_sel_high |-> miso_oe_n_o; endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven outside frame");
  property p_en1_low; !master_enable_one_i [*5] |-> fault_flag_n_o && status_flag_n_o; endproperty
  a_en1_low: assert property (p_en1_low) else $error("flag held with enable one low");
  property p_flag_pin; fault_flag_n_oe_n_o == fault_flag_n_o; endproperty
  a_flag_pin: assert property (p_flag_pin) else $error("fault flag enable and level disagree");
  property p_open_on; s_open_on |-> !status_flag_n_o; endproperty
  a_open_on: assert property (p_open_on) else $error("status flag not set");
  property p_open_off; s_open_off |-> status_flag_n_o; endproperty
  a_open_off: assert property (p_open_off) else $error("status flag not released");
  property p_gate_en; !(master_enable_one_i && master_enable_two_i) [*5] |-> gate_drive_o == '0; endproperty
  a_gate_en: assert property (p_gate_en) else $error("gate on with enable low");
  property p_gate_cmd; (cmd_in_i == '0) [*6] |-> gate_drive_o == '0; endproperty
  a_gate_cmd: assert property (p_gate_cmd) else $error("gate on without command");
  property p_fv_cause; frame_valid_o |-> $past(chip_select_n_i) && !$past(chip_select_n_i, 8) ##1 !frame_valid_o; endproperty
  a_fv_cause: assert property (p_fv_cause) else $error("frame pulse without frame end");
  property p_cfg_hold; !$stable(config_word_o) |-> frame_valid_o; endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without valid frame");
endmodule
bind fault_capture_readback fault_capture_readback_assertions #(
  .CHANNELS(CHANNELS),
  .RETRY_COUNT(RETRY_COUNT)
) u_fault_capture_readback_assertions (
  .clock_i(clock_i), .resetn_i(resetn_i),
  .master_enable_one_i(master_enable_one_i), .master_enable_two_i(master_enable_two_i),
  .cmd_in_i(cmd_in_i), .drain_below_open_i(drain_below_open_i), .flag_enable_i(flag_enable_i),
  .chip_select_n_i(chip_select_n_i), .miso_oe_n_o(miso_oe_n_o), .fault_flag_n_o(fault_flag_n_o),
  .fault_flag_n_oe_n_o(fault_flag_n_oe_n_o), .status_flag_n_o(status_flag_n_o),
  .gate_drive_o(gate_drive_o), .config_word_o(config_word_o), .frame_valid_o(frame_valid_o)
);
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Purpose: host serial master sending frames into the block
// Assumes: mode 0, 800 ns serial clock, msb first
// Notes: miso read late in high phase, clear of the update window
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clock_i,
  input wire logic miso_i,
  output logic chip_select_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // n below 16 gives a broken frame on purpose
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clock_i);
    chip_select_n_o <= 1'b0;
    repeat (8) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      mosi_o <= tx[15 - i];
      repeat (4) @(posedge clock_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clock_i);
      rx = {rx[14:0], miso_i};
      @(posedge clock_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clock_i);
    chip_select_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

/* File: tb/fault_capture_readback_tb.sv */
// Purpose: self-checking bench for fault capture and readback
// Assumes: retry shortened to 500 cycles
// Notes: latch model takes live codes at first capture and at valid frame ends
`timescale 1ns/1ps
`default_nettype none
module fault_capture_readback_tb;
  import fault_capture_pkg::*;
  localparam int RETRY = 500;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic en1 = 1'b0;
  logic en2 = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic [5:0] above = 6'h00;
  logic [5:0] bopen = 6'h00;
  logic [5:0] bgnd = 6'h00;
  logic [5:0] fen = 6'h3F;
  logic cs_n, sclk, mosi, miso, miso_oe_n, flt_n, flt_oe_n, sta_n, sta_oe_n, fv;
  logic [5:0] gate;
  logic [15:0] cfg;
  logic [15:0] cfg_exp = 16'h0000;
  logic [1:0] lat [6] = '{default: 2'h0};
  logic [31:0] seed = 32'h00001C36;
  int errors = 0;
  int total_checks = 0;
  int fv_cnt = 0;
  // open-drain flags pulled up; released miso toggles
  wire fl = flt_oe_n ? 1'b1 : flt_n;
  wire sl = sta_oe_n ? 1'b1 : sta_n;
  wire miso_w = miso_oe_n ? clock_i : miso;
  fault_capture_readback #(.CHANNELS(6), .RETRY_COUNT(RETRY)) u_fault_capture_readback (
    .clock_i(clock_i), .resetn_i(resetn_i), .master_enable_one_i(en1), .master_enable_two_i(en2),
    .cmd_in_i(cmd), .drain_above_short_ref_i(above), .drain_below_open_i(bopen),
    .drain_below_ground_i(bgnd), .flag_enable_i(fen), .chip_select_n_i(cs_n), .sclk_i(sclk),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n), .fault_flag_n_o(flt_n),
    .fault_flag_n_oe_n_o(flt_oe_n), .status_flag_n_o(sta_n), .status_flag_n_oe_n_o(sta_oe_n),
    .gate_drive_o(gate), .config_word_o(cfg), .frame_valid_o(fv)
  );
  spi_host_model u_spi_host_model (
    .clock_i(clock_i), .miso_i(miso_w), .chip_select_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi)
  );
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  // counts frame pulses so each frame can be held to its own outcome
  always @(posedge clock_i) begin
    if (fv === 1'b1) fv_cnt <= fv_cnt + 1;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [1:0] live(input int i);
    if (cmd[i]) return above[i] ? CODE_SHORT : CODE_NONE;
    return bgnd[i] ? CODE_GROUND : (bopen[i] ? CODE_OPEN : CODE_NONE);
  endfunction
  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic frame(input int n);
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] w;
    logic idle;
    int fv0;
    fv0 = fv_cnt;
    tx = rnd();
    w = 16'h0000;
    for (int i = 0; i < 6; i++) w[2*i +: 2] = lat[i];
    u_spi_host_model.xfer(tx, n, rx);
    chk(16'(fv_cnt - fv0), 16'(n == FRAME_BITS));
    if (n == 16) begin
      chk(rx, w);
      cfg_exp = tx;
      for (int i = 0; i < 6; i++) lat[i] = live(i);
    end
    idle = 1'b1;
    for (int i = 0; i < 6; i++) if (lat[i] != CODE_NONE) idle = 1'b0;
    chk(cfg, cfg_exp);
    chk({15'h0000, fl}, {15'h0000, idle});
  endtask
  initial begin
    repeat (30000) @(posedge clock_i);
    errors++;
    summarize();
  end
  initial begin
    int k;
    k = 0;
    cyc(10);
    chk({12'h000, miso_oe_n, flt_oe_n, sta_oe_n, fv}, 16'h000E);
    chk({10'h000, gate}, 16'h0000);
    chk(cfg, CONFIG_RESET);
    cyc(2);
    resetn_i <= 1'b1;
    cyc(8);
    en1 <= 1'b1;
    en2 <= 1'b1;
    cyc(260);
    chk({14'h0000, fl, sl}, 16'h0003);
    bopen[0] <= 1'b1;
    bopen[1] <= 1'b1;
    bgnd[1] <= 1'b1;
    cyc(160);
    lat[0] = live(0);
    lat[1] = live(1);
    chk({14'h0000, fl, sl}, 16'h0000);
    cmd[2] <= 1'b1;
    above[2] <= 1'b1;
    cyc(8);
    chk({15'h0000, gate[2]}, 16'h0001);
    cyc(230);
    lat[2] = live(2);
    chk({15'h0000, gate[2]}, 16'h0000);
    while (gate[2] !== 1'b1 && k < 800) begin
      cyc(1);
      k++;
    end
    // gate fell one filter time after the command, then waits one retry period
    chk(16'(k + 238 > FILTER_CYCLES + RETRY && k + 238 < FILTER_CYCLES + RETRY + 20), 16'h0001);
    cyc(230);
    chk({15'h0000, gate[2]}, 16'h0000);
    cmd[2] <= 1'b0;
    above[2] <= 1'b0;
    cyc(300);
    frame(16);
    bopen[0] <= 1'b0;
    cyc(150);
    frame(15);
    frame(16);
    frame(16);
    en1 <= 1'b0;
    cyc(10);
    en1 <= 1'b1;
    cyc(20);
    chk({15'h0000, fl}, 16'h0001);
    cyc(260);
    chk({15'h0000, fl}, 16'h0000);
    // mask all channels: both flags must let go
    fen <= 6'h00;
    cyc(6);
    chk({14'h0000, fl, sl}, 16'h0003);
    summarize();
  end
endmodule
`default_nettype wire
